// >>> core/move_exec_defs.vh
// Constants for the move and idle instruction executor.
// Assumes a 12-bit instruction word and a 32-entry, 8-bit file register space.
`ifndef MOVE_EXEC_DEFS_VH
`define MOVE_EXEC_DEFS_VH

// ----------------------------------------
// Instruction encodings
// ----------------------------------------
`define COPY_REG_MASK   12'hfc0
`define COPY_REG_CODE   12'h200
`define STORE_ACC_MASK  12'hfe0
`define STORE_ACC_CODE  12'h020
`define LOAD_CONST_MASK 12'hf00
`define LOAD_CONST_CODE 12'hc00
`define IDLE_CODE       12'h000
`define DEST_BIT        5
`define INDEX_MSB       4
`define CONST_MSB       7

// ----------------------------------------
// Timing
// ----------------------------------------
`define OSC_PER_CYCLE   4
`define PHASE_LAST      2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACC_RESET       8'h00
`define ZERO_RESET      1'b0

`endif

// >>> core/move_and_nop_instr_exec.v
// Executor for copy-register, store-accumulator, load-constant and idle words.
// Assumes instr holds a fetched word for a whole instruction cycle and that
// file register reads are combinational (reg_rdata follows reg_addr).
`include "move_exec_defs.vh"

module move_and_nop_instr_exec (
    input  wire        clk,
    input  wire        nrst,
    input  wire [11:0] instr,
    input  wire [7:0]  reg_rdata,
    output reg  [4:0]  reg_addr,
    output reg  [7:0]  reg_wdata,
    output reg         reg_we,
    output reg  [7:0]  acc,
    output reg         zero_flag,
    output reg         cycle_start,
    output reg         illegal
);

    // ----------------------------------------
    // Instruction word fields
    // ----------------------------------------
    // Slices are named once so the execute and write-port logic read as the encodings.
    wire [4:0] field_index;
    wire [7:0] field_const;
    wire       field_dest;

    assign field_index = instr[`INDEX_MSB:0];
    assign field_const = instr[`CONST_MSB:0];
    assign field_dest  = instr[`DEST_BIT];

    // ----------------------------------------
    // Quarter-cycle phase counter
    // ----------------------------------------
    // Plain edge-triggered flops only, no dynamic state: the clock may stop
    // at any phase and the instruction cycle resumes where it left off.
    reg  [1:0] phase;
    reg  [1:0] next_phase;
    wire       last_phase;

    assign last_phase = (phase == `PHASE_LAST);

    always @* begin
        next_phase = phase + 2'h1;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Decode is purely combinational; nothing is acted on before the last phase.
    wire is_copy;
    wire is_store;
    wire is_load;
    wire is_idle;
    wire is_known;

    assign is_copy  = ((instr & `COPY_REG_MASK) == `COPY_REG_CODE);
    assign is_store = ((instr & `STORE_ACC_MASK) == `STORE_ACC_CODE);
    assign is_load  = ((instr & `LOAD_CONST_MASK) == `LOAD_CONST_CODE);
    assign is_idle  = (instr == `IDLE_CODE);
    assign is_known = is_copy | is_store | is_load | is_idle;

    // ----------------------------------------
    // Execute strobes
    // ----------------------------------------
    // Each strobe is high on the last phase only, so one word executes once
    // per instruction cycle however long it is held.
    wire do_copy;
    wire do_store;
    wire do_load;
    wire do_copy_acc;
    wire do_copy_back;

    assign do_copy      = last_phase & is_copy;
    assign do_store     = last_phase & is_store;
    assign do_load      = last_phase & is_load;
    assign do_copy_acc  = do_copy & ~field_dest;
    assign do_copy_back = do_copy & field_dest;

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    reg  [7:0] next_acc;

    always @* begin
        next_acc = acc;
        if (do_copy_acc) begin
            next_acc = reg_rdata;
        end else if (do_load) begin
            next_acc = field_const;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc <= `ACC_RESET;
        end else begin
            acc <= next_acc;
        end
    end

    // ----------------------------------------
    // Zero status flag
    // ----------------------------------------
    // Only the copy-register word touches the flag; the other words keep it.
    reg        next_zero;

    always @* begin
        next_zero = zero_flag;
        if (do_copy) begin
            next_zero = (reg_rdata == 8'h00);
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            zero_flag <= `ZERO_RESET;
        end else begin
            zero_flag <= next_zero;
        end
    end

    // ----------------------------------------
    // File register write port
    // ----------------------------------------
    // The index follows the word one clock behind, so a read that depends on
    // it has settled by the last phase. Write data holds between writes.
    reg        next_we;
    reg  [7:0] next_wdata;
    reg  [4:0] next_addr;

    always @* begin
        next_we    = 1'b0;
        next_wdata = reg_wdata;
        next_addr  = field_index;
        if (do_copy_back) begin
            next_we    = 1'b1;
            next_wdata = reg_rdata;
        end else if (do_store) begin
            next_we    = 1'b1;
            next_wdata = acc;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_we <= 1'b0;
        end else begin
            reg_we <= next_we;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_wdata <= 8'h00;
        end else begin
            reg_wdata <= next_wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_addr <= 5'h00;
        end else begin
            reg_addr <= next_addr;
        end
    end

    // ----------------------------------------
    // Cycle marker
    // ----------------------------------------
    // One-clock pulse after every executed instruction cycle.
    reg        next_cycle_start;

    always @* begin
        next_cycle_start = last_phase;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cycle_start <= 1'b0;
        end else begin
            cycle_start <= next_cycle_start;
        end
    end

    // ----------------------------------------
    // Unhandled word flag
    // ----------------------------------------
    // Words outside the four handled ones do nothing but raise this level;
    // it is refreshed on every last phase, so it names the latest word.
    reg        next_illegal;

    always @* begin
        next_illegal = illegal;
        if (last_phase) begin
            next_illegal = ~is_known;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            illegal <= 1'b0;
        end else begin
            illegal <= next_illegal;
        end
    end

endmodule // move_and_nop_instr_exec

// >>> test/move_and_nop_instr_exec_asserts.sv
// Move executor port checker; bound from the bench top file.
// Assumes instr is held for a whole instruction cycle, as the bench does.
module move_exec_chk (input wire logic clk, nrst, reg_we, zero_flag, cycle_start,
    input wire logic [11:0] instr, input wire logic [7:0] reg_rdata, reg_wdata, acc);
timeunit 1ns; timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
a_cycle_gap: assert property (cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("gap");
a_copy_zero: assert property (cycle_start && $past(instr[11:6]) == 6'h08
    |-> zero_flag == !$past(reg_rdata)) else $error("zero");
a_copy_dest: assert property (cycle_start && $past(instr[11:6]) == 6'h08
    |-> reg_we == $past(instr[5])) else $error("dest");
a_store_acc: assert property (cycle_start && $past(instr[11:5]) == 7'h01
    |-> reg_we && reg_wdata == $past(acc)) else $error("store");
a_load_const: assert property (cycle_start && $past(instr[11:8]) == 4'hc
    |-> acc == $past(instr[7:0])) else $error("load");
a_acc_static: assert property ($changed(acc) |-> cycle_start) else $error("acc");
a_flag_keep: assert property (cycle_start && $past(instr[11:6]) != 6'h08
    |-> $stable(zero_flag)) else $error("flag");
a_idle_quiet: assert property (cycle_start && $past(instr) == 12'h000
    |-> !reg_we && $stable(acc)) else $error("idle");
endmodule // move_exec_chk

// >>> test/move_and_nop_instr_exec_test.sv
// Move executor bench; reads return index times eight.
// Assumes the executor runs one word per four clocks and tolerates a paused clock.
module move_and_nop_instr_exec_test;
timeunit 1ns; timeprecision 1ps;
localparam int n_instr = 64;
localparam int run_ns = (n_instr + 4) * 16 + 400;
logic clk = 0, nrst = 0, run = 1, reg_we, zero_flag, cycle_start, illegal, z = 0, we, il;
logic [11:0] instr = 0;
logic [7:0] reg_rdata, reg_wdata, acc, a = 0, v, wd;
logic [4:0] reg_addr, ad;
logic [2:0] sel;
logic [23:0] x, y, q [$];
int seed = 32'h24382377, n_fail = 0, checks_done = 0, r = 0;
assign reg_rdata = {reg_addr, 3'h0};
move_and_nop_instr_exec dut_u (
    .clk         (clk),
    .nrst        (nrst),
    .instr       (instr),
    .reg_rdata   (reg_rdata),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_we      (reg_we),
    .acc         (acc),
    .zero_flag   (zero_flag),
    .cycle_start (cycle_start),
    .illegal     (illegal)
);
// Clock holds its level while run is low
always #2 clk = run ? ~clk : clk;
initial #(2 * run_ns) begin n_fail++; final_report; end
task final_report;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
always @(negedge clk) if (cycle_start) begin
    y = {illegal, acc, zero_flag, reg_we, reg_we ? reg_wdata : 8'h00,
        reg_we ? reg_addr : 5'h00};
    checks_done++;
    if (q.size() == 0) begin
        n_fail++;
        $display("wrong value pending notes expected 1 seen 0");
    end else begin
        x = q.pop_front();
        if (x !== y) begin
            n_fail++;
            $display("wrong value state expected %h seen %h", x, y);
        end
    end
end
initial begin
    for (int i = 0; i < n_instr; i++) begin
        repeat (i ? 4 : 5) @(posedge clk);
        sel = (i < 8) ? i[2:0] : r[14:12];
        {we, wd, v, ad, il} = {9'h000, r[4:0], 3'h0, r[4:0], 1'b0};
        case (sel)
        0, 4: begin instr <= {6'h08, r[5:0]}; z = !v;
            if (r[5]) {we, wd} = {1'b1, v}; else a = v; end
        1, 5: begin instr <= {7'h01, r[4:0]}; {we, wd} = {1'b1, a}; end
        2, 6: begin instr <= {4'hc, r[7:0]}; a = r[7:0]; end
        3: instr <= 12'h000;
        default: begin instr <= {4'hf, r[7:0]}; il = 1; end
        endcase
        nrst <= 1;
        q.push_back({il, a, z, we, wd, we ? ad : 5'h00});
        if (i == n_instr / 2) begin run <= 0; #400 run <= 1; end
        r = $random(seed);
    end
    repeat (6) @(posedge clk);
    final_report;
end
endmodule // move_and_nop_instr_exec_test
bind move_and_nop_instr_exec move_exec_chk chk_u (.clk(clk), .nrst(nrst), .reg_we(reg_we),
    .zero_flag(zero_flag), .cycle_start(cycle_start), .instr(instr), .reg_rdata(reg_rdata),
    .reg_wdata(reg_wdata), .acc(acc));
